// [hw/thc_crc16.sv]
// Bit-serial frame check generator, least significant bit first.
// Assumes the caller feeds one bit per enable and presets with init between frames.
`timescale 1ns/1ps
`include "thc_consts.svh"
module thc_crc16
  import thc_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic init,
  input wire logic enable,
  input wire logic dataBit,
  output logic [15:0] crcNext
);

  logic [15:0] crc;

  // The next value is visible in the same cycle, so the last data bit is in the sum when the check is loaded.
  always_comb begin
    crcNext = crc;
    if (enable) begin
      crcNext = {1'b0, crc[15:1]} ^ ((crc[0] ^ dataBit) ? `THC_CRC_POLY : 16'h0000);
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst || init) begin
      crc <= `THC_CRC_INIT;
    end else begin
      crc <= crcNext;
    end
  end

endmodule

// [hw/thc_msg_fifo.sv]
// Transmit message store with a replay mark, so that a whole message can be sent again.
// Assumes one push and one pop per cycle at most, and that a message fits in the store.
`timescale 1ns/1ps
`include "thc_consts.svh"
module thc_msg_fifo
  import thc_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic push,
  input wire logic [9:0] pushData,
  input wire logic pop,
  input wire logic rewind,
  input wire logic commit,
  input wire logic flush,
  output logic [9:0] headData,
  output logic avail,
  output logic full,
  output logic [`THC_PTR_W-1:0] level
);

  logic [9:0] mem [`THC_FIFO_DEPTH];
  logic [`THC_PTR_W-1:0] wrPtr;
  logic [`THC_PTR_W-1:0] rdPtr;
  logic [`THC_PTR_W-1:0] startPtr;

  // Space is freed only on commit or flush; a message that may loop keeps its bytes until it is done.
  assign level = wrPtr - startPtr;
  assign full = level == `THC_PTR_W'(`THC_FIFO_DEPTH);
  assign avail = rdPtr != wrPtr;
  assign headData = mem[rdPtr[`THC_PTR_W-2:0]];

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wrPtr[`THC_PTR_W-2:0]] <= pushData;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      startPtr <= '0;
    end else begin
      if (push) begin
        wrPtr <= wrPtr + `THC_PTR_W'(1);
      end
      if (flush) begin
        rdPtr <= wrPtr;
        startPtr <= wrPtr;
      end else begin
        if (rewind) begin
          rdPtr <= startPtr;
        end else if (pop) begin
          rdPtr <= rdPtr + `THC_PTR_W'(1);
        end
        if (commit) begin
          startPtr <= rdPtr;
        end
      end
    end
  end

endmodule

// [hw/thc_transmit_hdlc_controller.sv]
// Transmit link controller of one framer port: registers, message store, framing and bit mapping.
// Assumes the framer supplies one-cycle bit-time strobes on core_clk and takes txBit when txBitValid.
`timescale 1ns/1ps
`include "thc_consts.svh"
// Function
// RL1: One flag between messages when the flag count bit is 0, two when 1.
// RL2: A message closed with the loop bit set repeats until cleared or new data.
// RL3: Clearing the loop bit finishes the current copy, then flags until new data; the code sends the fill byte, FFh when fill select is 1.
// RL4: New data during a loop ends it: flags, then the new message.
// RL5: A two-byte check follows every message unless the check defeat bit is set.
// RL6: Software sets end-of-message just before writing a message's last byte.
// RL7: Controller reset flushes the store, sends an abort, then fill until data.
// RL8: Controller reset bit clears itself, well within 250 microseconds.
// RL9: Mapping bit picks the selected channel or the facility link bits.
// RL10: Fill between messages is 7Eh when fill select is 0, FFh when 1.
// RL11: A zero follows five ones inside a message unless stuffing is defeated.
// RL12: Each set suppress bit removes that channel bit position from use.
// RL13: A rising abort bit dumps the store, sends FEh once, then fill.
// RL14: In T1 mode the send-code bit transmits the six-bit code repeatedly.
// RL15: The controller sends nothing while its enable bit is 0.
// RL16: A new carrier channel takes effect only at a controller reset.
// RL17: Control registers at 110h, 111h, 113h per port; all bits reset to 0.
// RL18: Frame check is the reflected CRC-16, ones preset, complement sent.
module thc_transmit_hdlc_controller
  import thc_pkg::*;
#(
  parameter int RESET_LIMIT_CYCLES = `THC_RESET_MAX_CYC
)
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [`THC_ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  input wire logic t1Mode,
  input wire logic facilityEnable,
  input wire logic channelBitSlot,
  input wire logic [4:0] channelIndex,
  input wire logic [2:0] channelBitPos,
  input wire logic facilityBitSlot,
  output logic txBit,
  output logic txBitValid
);

  logic [7:0] ctrlOne;
  logic [7:0] suppress;
  logic [7:0] ctrlTwo;
  logic [5:0] codeReg;
  logic [4:0] activeChannel;
  logic abortPrev;
  thc_state_t state;
  thc_state_t next_state;
  logic [7:0] shifter;
  logic [7:0] next_byte;
  logic [2:0] bitCnt;
  logic [2:0] ones;
  logic extraFlag;
  logic next_extra;
  logic curEom;
  logic curLoop;
  logic [7:0] crcHigh;
  logic [7:0] next_crcHigh;
  logic codePhase;
  logic fifoPop;
  logic fifoRewind;
  logic fifoCommit;
  logic fifoDrop;
  logic msgEnd;
  logic [9:0] headData;
  logic fifoAvail;
  logic fifoFull;
  logic [`THC_PTR_W-1:0] fifoLevel;
  logic [15:0] crcNext;

  wire logic txReset = ctrlOne[`THC_B1_RESET];
  wire logic abortRise = ctrlTwo[`THC_B2_ABORT] && !abortPrev;
  wire logic enable = ctrlTwo[`THC_B2_ENABLE];
  wire logic codeWanted = ctrlTwo[`THC_B2_SEND_BIT_CODE] && t1Mode;
  wire logic fifoPush = regWrite && regAddr == `THC_REG_FIFO && !fifoFull;
  wire logic inMsg = state == ST_DATA || state == ST_CRC_LO || state == ST_CRC_HI;
  wire logic [7:0] fillByte = ctrlOne[`THC_B1_FILLSEL] ? `THC_IDLE_BYTE : `THC_FLAG_BYTE;
  wire logic chanOk = channelBitSlot && channelIndex == activeChannel && !suppress[channelBitPos];
  wire logic factOk = facilityBitSlot && (t1Mode || facilityEnable);
  wire logic bitSlot = enable && !txReset && !abortRise && (ctrlOne[`THC_B1_MAP] ? factOk : chanOk);
  // The run counter only grows on message bits, so a run of five that ends the check still gets its zero.
  wire logic stuffNow = !ctrlOne[`THC_B1_ZSD] && ones == `THC_STUFF_RUN;
  wire logic byteDone = bitSlot && !stuffNow && bitCnt == 3'h7;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ctrlOne <= `THC_CTRL_ONE_RST; // [RL17]
    end else if (regWrite && regAddr == `THC_REG_CTRL_ONE) begin
      ctrlOne <= regWrData;
    end else begin
      // End-of-message marks only the byte written right after it.
      if (fifoPush) begin
        ctrlOne[`THC_B1_EOM] <= 1'b0; // [RL6]
      end
      if (txReset) begin
        ctrlOne[`THC_B1_RESET] <= 1'b0; // [RL8]
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      suppress <= `THC_SUPPRESS_RST;
      ctrlTwo <= `THC_CTRL_TWO_RST;
      codeReg <= `THC_CODE_RST;
    end else if (regWrite) begin
      if (regAddr == `THC_REG_SUPPRESS) begin
        suppress <= regWrData;
      end
      if (regAddr == `THC_REG_CTRL_TWO) begin
        ctrlTwo <= regWrData;
      end
      if (regAddr == `THC_REG_CODE) begin
        codeReg <= regWrData[5:0];
      end
    end
  end

  // The channel is latched only at a controller reset so a change never lands mid-byte.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      activeChannel <= 5'h00;
      abortPrev <= 1'b0;
    end else begin
      abortPrev <= ctrlTwo[`THC_B2_ABORT]; // [RL13]
      if (txReset) begin
        activeChannel <= ctrlTwo[4:0]; // [RL16]
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      regRdData <= 8'h00;
    end else if (regRead) begin
      unique case (regAddr)
        `THC_REG_CTRL_ONE: regRdData <= ctrlOne;
        `THC_REG_SUPPRESS: regRdData <= suppress;
        `THC_REG_CTRL_TWO: regRdData <= ctrlTwo;
        `THC_REG_CODE: regRdData <= {2'h0, codeReg};
        `THC_REG_STATUS: regRdData <= {fifoFull, !fifoAvail, curLoop && inMsg, fifoLevel};
        default: regRdData <= 8'h00;
      endcase
    end else begin
      regRdData <= 8'h00;
    end
  end

  thc_msg_fifo u_fifo (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .push(fifoPush),
    .pushData({ctrlOne[`THC_B1_LOOP], ctrlOne[`THC_B1_EOM] | ctrlOne[`THC_B1_LOOP], regWrData}),
    .pop(byteDone && fifoPop),
    .rewind(byteDone && fifoRewind),
    .commit(byteDone && fifoCommit),
    .flush(txReset || abortRise || (byteDone && fifoDrop)), // [RL7] [RL13]
    .headData(headData),
    .avail(fifoAvail),
    .full(fifoFull),
    .level(fifoLevel)
  );

  thc_crc16 u_crc (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .init(state != ST_DATA),
    .enable(bitSlot && !stuffNow && state == ST_DATA),
    .dataBit(shifter[0]),
    .crcNext(crcNext)
  );

  // Choice of the next byte, taken at the last bit of the current one.
  always_comb begin
    next_state = state;
    next_byte = fillByte;
    next_extra = extraFlag;
    next_crcHigh = crcHigh;
    fifoPop = 1'b0;
    fifoRewind = 1'b0;
    fifoCommit = 1'b0;
    fifoDrop = 1'b0;
    msgEnd = 1'b0;
    unique case (state)
      ST_FLAG: begin
        if (extraFlag) begin
          next_byte = `THC_FLAG_BYTE;
          next_extra = 1'b0;
        end else if (fifoAvail) begin
          next_state = ST_DATA;
          next_byte = headData[7:0];
          fifoPop = 1'b1;
        end else begin
          next_state = ST_FILL; // [RL10]
        end
      end
      ST_FILL, ST_ABORT, ST_CODE: begin
        if (codeWanted) begin
          next_state = ST_CODE; // [RL14]
          next_byte = codePhase ? {1'b0, codeReg, 1'b0} : `THC_IDLE_BYTE;
        end else if (fifoAvail) begin
          next_state = ST_FLAG;
          next_byte = `THC_FLAG_BYTE;
          next_extra = 1'b0;
        end else begin
          next_state = ST_FILL; // [RL10]
        end
      end
      ST_DATA: begin
        if (curEom && !ctrlOne[`THC_B1_CRCD]) begin
          next_state = ST_CRC_LO; // [RL5]
          next_byte = ~crcNext[7:0]; // [RL18]
          next_crcHigh = ~crcNext[15:8];
        end else if (curEom) begin
          msgEnd = 1'b1;
        end else if (fifoAvail) begin
          next_byte = headData[7:0];
          fifoPop = 1'b1;
        end else begin
          // Running dry inside a message would corrupt it, so it is aborted instead.
          next_state = ST_ABORT;
          next_byte = `THC_ABORT_BYTE;
          fifoDrop = 1'b1;
        end
      end
      ST_CRC_LO: begin
        next_state = ST_CRC_HI;
        next_byte = crcHigh;
      end
      ST_CRC_HI: begin
        msgEnd = 1'b1;
      end
    endcase
    if (msgEnd) begin
      next_state = ST_FLAG;
      next_byte = `THC_FLAG_BYTE;
      next_extra = ctrlOne[`THC_B1_FLAGS]; // [RL1]
      if (curLoop && ctrlOne[`THC_B1_LOOP] && !fifoAvail) begin
        fifoRewind = 1'b1; // [RL2]
      end else begin
        fifoCommit = 1'b1; // [RL3] [RL4]
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state <= ST_FILL;
      shifter <= `THC_FLAG_BYTE;
      bitCnt <= 3'h0;
      ones <= 3'h0;
      extraFlag <= 1'b0;
      curEom <= 1'b0;
      curLoop <= 1'b0;
      crcHigh <= 8'h00;
      codePhase <= 1'b0;
    end else if (txReset || abortRise) begin
      state <= ST_ABORT; // [RL7] [RL13]
      shifter <= `THC_ABORT_BYTE;
      bitCnt <= 3'h0;
      ones <= 3'h0;
      extraFlag <= 1'b0;
      curEom <= 1'b0;
      curLoop <= 1'b0;
      codePhase <= 1'b0;
    end else if (bitSlot) begin
      if (stuffNow) begin
        ones <= 3'h0; // [RL11]
      end else begin
        ones <= (inMsg && shifter[0]) ? ones + 3'h1 : 3'h0;
        bitCnt <= bitCnt + 3'h1;
        if (bitCnt == 3'h7) begin
          state <= next_state;
          shifter <= next_byte;
          extraFlag <= next_extra;
          crcHigh <= next_crcHigh;
          codePhase <= next_state == ST_CODE ? !codePhase : 1'b0;
          if (fifoPop) begin
            curLoop <= headData[9];
            curEom <= headData[8];
          end
        end else begin
          shifter <= {1'b0, shifter[7:1]};
        end
      end
    end
  end

  // Bits leave least significant first; txBit holds its last value between slots and is high from reset until the first slot.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      txBit <= 1'b1;
      txBitValid <= 1'b0;
    end else begin
      txBitValid <= bitSlot; // [RL9] [RL12] [RL15]
      if (bitSlot) begin
        txBit <= stuffNow ? 1'b0 : shifter[0];
      end
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  logic [31:0] resetAge;
  always_ff @(posedge core_clk) begin
    if (sys_rst || !txReset) begin
      resetAge <= 32'h0000_0000;
    end else begin
      resetAge <= resetAge + 32'h0000_0001;
    end
  end

  sequence msgEndSeq;
    byteDone && msgEnd;
  endsequence

  a_flag_count: assert property (msgEndSeq |=> state == ST_FLAG && extraFlag == $past(ctrlOne[7])) // [RL1]
    else $error("flag count after message wrong");
  a_loop_replay: assert property (msgEndSeq ##0 (curLoop && ctrlOne[6] && !fifoAvail) |=> fifoAvail) // [RL2]
    else $error("looped message not replayed");
  a_loop_stop: assert property (msgEndSeq ##0 (!ctrlOne[6] && !fifoAvail)
                                |=> fifoAvail == $past(fifoPush) && state == ST_FLAG) // [RL3]
    else $error("loop did not stop");
  a_loop_new: assert property (msgEndSeq ##0 fifoAvail |=> state == ST_FLAG ##0 fifoAvail) // [RL4]
    else $error("new message not queued after flags");
  a_crc_append: assert property (byteDone && state == ST_DATA && curEom
                                 |=> state == ($past(ctrlOne[0]) ? ST_FLAG : ST_CRC_LO)) // [RL5]
    else $error("check bytes wrong after last byte");
  a_reset_abort: assert property (txReset
                                  |=> state == ST_ABORT && shifter == 8'hFE && fifoAvail == $past(fifoPush)) // [RL7]
    else $error("reset did not abort and flush");
  a_reset_clear: assert property ($rose(txReset) |=> !txReset ##0 (resetAge < RESET_LIMIT_CYCLES)) // [RL8]
    else $error("reset bit did not clear");
  a_fill_byte: assert property (byteDone && state == ST_FILL && !fifoAvail && !codeWanted
                                |=> shifter == ($past(ctrlOne[3]) ? 8'hFF : 8'h7E)) // [RL10]
    else $error("fill byte wrong");
  a_stuff_zero: assert property (bitSlot && stuffNow |=> txBitValid && !txBit ##1 !stuffNow) // [RL11]
    else $error("zero not stuffed after five ones");
  a_suppress_bit: assert property (!ctrlOne[4] && channelBitSlot && suppress[channelBitPos]
                                   |=> !txBitValid) // [RL12]
    else $error("suppressed bit used");
  a_abort_edge: assert property ($rose(ctrlTwo[7]) |=> state == ST_ABORT && fifoAvail == $past(fifoPush)) // [RL13]
    else $error("abort edge not acted on");
  a_code_t1: assert property (state == ST_CODE |-> $past(t1Mode) || !$past(byteDone)) // [RL14]
    else $error("code sent outside T1 mode");
  a_disabled_quiet: assert property (!enable |=> !txBitValid) // [RL15]
    else $error("output while disabled");
  a_channel_hold: assert property (!txReset |=> $stable(activeChannel)) // [RL16]
    else $error("channel changed without reset");

endmodule

// [include/thc_consts.svh]
// Register map, field positions, reset values and timing counts of the transmit link controller.
// Assumes one port's register space; a wider system adds the per-port stride outside this block.
`ifndef THC_CONSTS_SVH
`define THC_CONSTS_SVH

`define THC_ADDR_W 9
`define THC_PORT_STRIDE 12'h200
`define THC_REG_CTRL_ONE 9'h110
`define THC_REG_SUPPRESS 9'h111
`define THC_REG_CTRL_TWO 9'h113
`define THC_REG_CODE 9'h115
`define THC_REG_FIFO 9'h116
`define THC_REG_STATUS 9'h117

`define THC_CTRL_ONE_RST 8'h00
`define THC_SUPPRESS_RST 8'h00
`define THC_CTRL_TWO_RST 8'h00
`define THC_CODE_RST 6'h00

`define THC_B1_FLAGS 7
`define THC_B1_LOOP 6
`define THC_B1_RESET 5
`define THC_B1_MAP 4
`define THC_B1_FILLSEL 3
`define THC_B1_EOM 2
`define THC_B1_ZSD 1
`define THC_B1_CRCD 0
`define THC_B2_ABORT 7
`define THC_B2_SEND_BIT_CODE 6
`define THC_B2_ENABLE 5

`define THC_FLAG_BYTE 8'h7E
`define THC_IDLE_BYTE 8'hFF
`define THC_ABORT_BYTE 8'hFE
`define THC_CRC_POLY 16'h8408
`define THC_CRC_INIT 16'hFFFF
`define THC_STUFF_RUN 3'h5

`define THC_FIFO_DEPTH 16
`define THC_PTR_W 5

`define THC_CLK_PERIOD_NS 5
`define THC_RESET_MAX_NS 250000
`define THC_RESET_MAX_CYC ((`THC_RESET_MAX_NS) / (`THC_CLK_PERIOD_NS))

`endif

// [include/thc_pkg.sv]
// Types shared by the transmit link controller files.
// Assumes nothing beyond a SystemVerilog compiler.
package thc_pkg;

  typedef enum logic [2:0] {
    ST_FILL,
    ST_FLAG,
    ST_DATA,
    ST_CRC_LO,
    ST_CRC_HI,
    ST_ABORT,
    ST_CODE
  } thc_state_t;

endpackage

// [testbench/tb_transmit_hdlc_controller.sv]
// Self-checking bench of the transmit link controller, with the framer model pacing bit times.
// Assumes the register map of thc_consts.svh and bytes sent LSB first.
`timescale 1ns/1ps
`include "thc_consts.svh"
module tb_transmit_hdlc_controller;
  logic core_clk, sys_rst, regWrite, regRead, t1Mode, facilityEnable, slow;
  logic [8:0] regAddr;
  logic [7:0] regWrData, regRdData, expSup, st;
  logic channelBitSlot, facilityBitSlot, txBit, txBitValid, monOn, expMap, pFac;
  logic [4:0] channelIndex, expChan, pIdx;
  logic [2:0] channelBitPos, pPos;
  logic rxq[$];
  logic exq[$];
  int fail_count, cmp_count, cycles, vcount, ones, c1;
  logic [15:0] crc;

  thc_transmit_hdlc_controller thc_transmit_hdlc_controller_inst (.core_clk(core_clk), .sys_rst(sys_rst),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .t1Mode(t1Mode), .facilityEnable(facilityEnable), .channelBitSlot(channelBitSlot),
    .channelIndex(channelIndex), .channelBitPos(channelBitPos), .facilityBitSlot(facilityBitSlot),
    .txBit(txBit), .txBitValid(txBitValid));
  thc_framer_model thc_framer_model_inst (.core_clk(core_clk), .sys_rst(sys_rst), .slow(slow),
    .channelBitSlot(channelBitSlot), .channelIndex(channelIndex), .channelBitPos(channelBitPos),
    .facilityBitSlot(facilityBitSlot));

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 60000) begin
      fail_count++;
      report_and_stop();
    end
  end

  // Every bit on the line while monOn is set must come from a slot the controller was allowed to use.
  always @(posedge core_clk) begin
    if (txBitValid === 1'b1) begin
      rxq.push_back(txBit);
      vcount++;
      if (monOn && expMap) chk(16'(pFac), 16'h1);
      if (monOn && !expMap) chk({8'(pIdx), 8'(expSup[pPos])}, {8'(expChan), 8'h0});
    end
    pFac <= facilityBitSlot;
    pIdx <= channelIndex;
    pPos <= channelBitPos;
  end

  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge core_clk);
    regWrite <= 1'b0;
  endtask

  task automatic rd(input logic [8:0] a, output logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge core_clk);
    regRead <= 1'b0;
    #1 d = regRdData;
  endtask

  task automatic put(input logic [7:0] b, input logic stuff);
    for (int i = 0; i < 8; i++) begin
      exq.push_back(b[i]);
      ones = b[i] ? ones + 1 : 0;
      if (stuff && ones == 5) begin
        exq.push_back(1'b0);
        ones = 0;
      end
    end
  endtask

  task automatic add_byte(input logic [7:0] b, input logic stuff);
    put(b, stuff);
    for (int i = 0; i < 8; i++) crc = (crc[0] ^ b[i]) ? (crc >> 1) ^ 16'h8408 : crc >> 1;
  endtask

  // Fill is all ones here, so the first zero after the mark opens the expected pattern.
  task automatic match(input int mark);
    int i;
    int n;
    i = mark;
    for (int w = 0; w < 8000 && rxq.size() < mark + exq.size() + 80; w++) @(posedge core_clk);
    while (i < rxq.size() && rxq[i] !== 1'b0) i++;
    n = 0;
    for (int k = 0; k < exq.size(); k++) if (i + k < rxq.size() && rxq[i + k] === exq[k]) n++;
    chk(16'(n), 16'(exq.size()));
  endtask

  task automatic test_registers();
    rd(`THC_REG_CODE, st);
    chk(16'(st), 16'h0000);
    rd(`THC_REG_CTRL_ONE, st);
    chk(16'(st), 16'h0000);
    rd(`THC_REG_SUPPRESS, st);
    chk(16'(st), 16'h0000);
    rd(`THC_REG_CTRL_TWO, st);
    chk(16'(st), 16'h0000);
    wr(9'h112, 8'h5A);
    rd(9'h112, st);
    chk(16'(st), 16'h0000);
    wr(`THC_REG_SUPPRESS, 8'hA5);
    expSup = 8'hA5;
    rd(`THC_REG_SUPPRESS, st);
    chk(16'(st), 16'h00A5);
  endtask

  task automatic test_abort(input logic viaReset);
    int mark;
    wr(`THC_REG_CTRL_ONE, 8'h0A);
    repeat (8) wr(`THC_REG_FIFO, 8'hFF);
    slow <= 1'b1;
    repeat (120) @(posedge core_clk);
    exq.delete();
    put(8'hFE, 1'b0);
    put(8'hFF, 1'b0);
    put(8'hFF, 1'b0);
    mark = rxq.size();
    if (viaReset) begin
      monOn = 1'b0;
      wr(`THC_REG_CTRL_ONE, 8'h2A);
      repeat (2) @(posedge core_clk);
      rd(`THC_REG_CTRL_ONE, st);
      chk(16'(st), 16'h000A);
      expChan = 5'd1;
      monOn = 1'b1;
    end else begin
      wr(`THC_REG_CTRL_TWO, 8'hA1);
      wr(`THC_REG_CTRL_TWO, 8'h21);
    end
    rd(`THC_REG_STATUS, st);
    chk(16'(st), 16'h0040);
    match(mark);
    slow <= 1'b0;
  endtask

  task automatic test_message(input logic flags, input logic zsd, input logic crcd);
    int mark;
    logic [7:0] cfg;
    cfg = {flags, 3'b000, 1'b1, 1'b0, zsd, crcd};
    wr(`THC_REG_CTRL_ONE, cfg);
    repeat (20) @(posedge core_clk);
    exq.delete();
    put(8'h7E, 1'b0);
    ones = 0;
    crc = 16'hFFFF;
    add_byte(8'hFF, !zsd);
    add_byte(8'h3C, !zsd);
    if (!crcd) put(~crc[7:0], !zsd);
    if (!crcd) put(~crc[15:8], !zsd);
    put(8'h7E, 1'b0);
    if (flags) put(8'h7E, 1'b0);
    put(8'hFF, 1'b0);
    put(8'hFF, 1'b0);
    mark = rxq.size();
    wr(`THC_REG_FIFO, 8'hFF);
    wr(`THC_REG_CTRL_ONE, cfg | 8'h04);
    wr(`THC_REG_FIFO, 8'h3C);
    match(mark);
  endtask

  task automatic test_loop_and_code();
    int mark;
    wr(`THC_REG_CTRL_ONE, 8'h48);
    wr(`THC_REG_FIFO, 8'h81);
    repeat (200) @(posedge core_clk);
    rd(`THC_REG_STATUS, st);
    chk(16'(st[5]), 16'h1);
    wr(`THC_REG_FIFO, 8'h55);
    repeat (400) @(posedge core_clk);
    rd(`THC_REG_STATUS, st);
    chk(16'(st[4:0]), 16'h0001);
    wr(`THC_REG_CTRL_ONE, 8'h08);
    repeat (400) @(posedge core_clk);
    rd(`THC_REG_STATUS, st);
    chk(16'(st & 8'h60), 16'h0040);
    t1Mode <= 1'b1;
    wr(`THC_REG_CODE, 8'h15);
    exq.delete();
    put(8'h2A, 1'b0);
    put(8'hFF, 1'b0);
    put(8'h2A, 1'b0);
    mark = rxq.size();
    wr(`THC_REG_CTRL_TWO, 8'h61);
    match(mark);
    wr(`THC_REG_CTRL_TWO, 8'h21);
  endtask

  task automatic test_map_and_enable();
    wr(`THC_REG_CTRL_TWO, 8'h01);
    wr(`THC_REG_CTRL_ONE, 8'h18);
    expMap = 1'b1;
    wr(`THC_REG_CTRL_TWO, 8'h21);
    repeat (200) @(posedge core_clk);
    t1Mode <= 1'b0;
    repeat (4) @(posedge core_clk);
    c1 = vcount;
    repeat (200) @(posedge core_clk);
    chk(16'(vcount - c1), 16'h0000);
    facilityEnable <= 1'b1;
    repeat (200) @(posedge core_clk);
    chk(16'(vcount > c1 + 2), 16'h0001);
    wr(`THC_REG_CTRL_TWO, 8'h01);
    wr(`THC_REG_CTRL_ONE, 8'h08);
    expMap = 1'b0;
    repeat (4) @(posedge core_clk);
    c1 = vcount;
    repeat (200) @(posedge core_clk);
    chk(16'(vcount - c1), 16'h0000);
  endtask

  initial begin
    sys_rst = 1'b1;
    {regWrite, regRead, t1Mode, facilityEnable, slow, monOn, expMap} = '0;
    regAddr = '0;
    regWrData = '0;
    expSup = '0;
    expChan = '0;
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    test_registers();
    monOn = 1'b1;
    wr(`THC_REG_CTRL_TWO, 8'h21);
    repeat (100) @(posedge core_clk);
    test_abort(1'b1);
    test_abort(1'b0);
    test_message(1'b0, 1'b0, 1'b0);
    test_message(1'b1, 1'b1, 1'b1);
    test_loop_and_code();
    test_map_and_enable();
    report_and_stop();
  end
endmodule

// [testbench/thc_framer_model.sv]
// Framer-side model: paces payload and facility bit times toward the transmit link controller.
// Assumes a short frame of CHANNELS channels of eight bits, MSB position first, then one facility bit.
`timescale 1ns/1ps
module thc_framer_model #(
  parameter int CHANNELS = 4
)
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic slow,
  output logic channelBitSlot,
  output logic [4:0] channelIndex,
  output logic [2:0] channelBitPos,
  output logic facilityBitSlot
);
  logic [7:0] slotNum;
  logic [1:0] pace;
  logic fire;
  assign fire = !slow || pace == 2'd3;
  // Between strobes the index and position keep toggling, so only the strobe may qualify them.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pace <= 2'd0;
      slotNum <= 8'd0;
      channelBitSlot <= 1'b0;
      facilityBitSlot <= 1'b0;
      channelIndex <= 5'd0;
      channelBitPos <= 3'd0;
    end else begin
      pace <= pace + 2'd1;
      channelBitSlot <= fire && slotNum < 8'(CHANNELS * 8);
      facilityBitSlot <= fire && slotNum == 8'(CHANNELS * 8);
      channelIndex <= fire ? slotNum[7:3] : ~channelIndex;
      channelBitPos <= fire ? ~slotNum[2:0] : ~channelBitPos;
      if (fire) begin
        slotNum <= (slotNum == 8'(CHANNELS * 8)) ? 8'd0 : slotNum + 8'd1;
      end
    end
  end
endmodule
